// ---- shared/itptc_pkg.sv ----
/*
 * Constants, carrier types and shared arithmetic for the inductive transmitter power control.
 * Assumes a single 10 MHz clock; frequency is kept in Hz, voltage in half-millivolt units.
 */
`default_nettype none
package itptc_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned CLK_CYC_PER_US  = CLK_HZ / 1_000_000;
	localparam int unsigned PING_WAIT_US    = 70_000;
	localparam int unsigned GAP_US          = 10_000;
	localparam int unsigned PING_WAIT_CYC_DEF = PING_WAIT_US * CLK_CYC_PER_US;
	localparam int unsigned GAP_CYC_DEF       = GAP_US * CLK_CYC_PER_US;
	localparam int          CNT_W           = 20;

	localparam int          FREQ_W          = 18;
	localparam int          VOLT_W          = 15;
	localparam int          MV_W            = 14;
	localparam int          CUR_W           = 12;
	localparam int          CE_W            = 8;
	localparam int          ERR_W           = 21;
	localparam int          ACC_W           = 22;
	localparam int          CE_SHIFT        = 7;

	localparam logic [FREQ_W-1:0] FREQ_MIN_HZ   = 18'h1adb0;
	localparam logic [FREQ_W-1:0] FREQ_MAX_HZ   = 18'h2bf20;
	localparam logic [FREQ_W-1:0] FREQ_PING_HZ  = 18'h1fbd0;
	localparam logic [FREQ_W-1:0] FREQ_STEP_HZ  = 18'h001f4;
	localparam logic [VOLT_W-1:0] VOLT_MIN_HMV  = 15'h2710;
	localparam logic [VOLT_W-1:0] VOLT_MAX_HMV  = 15'h55f0;
	localparam logic [VOLT_W-1:0] VOLT_PING_HMV = 15'h3e80;
	localparam logic [VOLT_W-1:0] VOLT_RETRY_STEP_HMV = 15'h03e8;
	localparam logic [7:0]        STRENGTH_MIN  = 8'h01;

	localparam logic signed [CE_W-1:0]  PROPORTIONAL_GAIN = 8'sh01;
	localparam logic signed [CE_W-1:0]  INTEGRAL_GAIN     = 8'sh00;
	localparam logic signed [CE_W-1:0]  DERIVATIVE_GAIN   = 8'sh00;
	localparam logic signed [ERR_W-1:0] LOOP_OUTPUT_LIMIT_FREQ = 21'sh004e20;
	localparam logic signed [ERR_W-1:0] LOOP_OUTPUT_LIMIT_VOLT = 21'sh0005dc;

	typedef enum logic {PKT_STRENGTH, PKT_CTRL_ERR} itptc_kind_t;

	typedef struct packed {
		logic        valid;
		itptc_kind_t kind;
		logic [7:0]  value;
	} itptc_rx_t;

	typedef struct packed {
		logic              power_on;
		logic [FREQ_W-1:0] freq_hz;
		logic [MV_W-1:0]   volt_mv;
	} itptc_cmd_t;

	typedef enum logic [1:0] {ST_IDLE, ST_PING, ST_GAP, ST_RUN} itptc_state_t;

	function automatic logic signed [ERR_W-1:0] itptc_sat(
		input logic signed [ERR_W-1:0] x,
		input logic signed [ERR_W-1:0] lim);
		if (x > lim) return lim;
		if (x < -lim) return -lim;
		return x;
	endfunction : itptc_sat

	function automatic logic signed [ACC_W-1:0] itptc_clamp(
		input logic signed [ACC_W-1:0] x,
		input logic signed [ACC_W-1:0] lo,
		input logic signed [ACC_W-1:0] hi);
		if (x < lo) return lo;
		if (x > hi) return hi;
		return x;
	endfunction : itptc_clamp
endpackage : itptc_pkg
`default_nettype wire

// ---- rtl/itptc_pid.sv ----
/*
 * One proportional loop update: control error and coil current in, next frequency and voltage out.
 * Assumes the caller registers the results and presents in-range present values.
 */
`timescale 1ns/1ps
`default_nettype none
module itptc_pid
	import itptc_pkg::*;
(
	input  wire logic [CUR_W-1:0]  coil_ma_i,
	input  wire logic [CE_W-1:0]   ctrl_err_i,
	input  wire logic [FREQ_W-1:0] freq_i,
	input  wire logic [VOLT_W-1:0] volt_i,
	output logic      [FREQ_W-1:0] freq_o,
	output logic      [VOLT_W-1:0] volt_o
);
	logic signed [CUR_W:0]        cur_s;
	logic signed [CUR_W+CE_W:0]   prod;
	logic signed [ERR_W-1:0]      err;
	logic signed [ERR_W-1:0]      pid_f;
	logic signed [ERR_W-1:0]      pid_v;
	logic signed [ACC_W-1:0]      f_cand;
	logic signed [ACC_W-1:0]      v_cand;
	logic                         at_edge;

	always_comb begin
		cur_s = $signed({1'b0, coil_ma_i});
		// Target current is measured current scaled by (1 + error/128)
		prod  = cur_s * $signed(ctrl_err_i);
		err   = ERR_W'(prod >>> CE_SHIFT);
		// Integral and derivative gains are zero, so only the proportional path exists
		pid_f = itptc_sat(ERR_W'(err * PROPORTIONAL_GAIN), LOOP_OUTPUT_LIMIT_FREQ);
		pid_v = itptc_sat(ERR_W'(err * PROPORTIONAL_GAIN), LOOP_OUTPUT_LIMIT_VOLT);
		// Frequency moves by -1 Hz per unit, voltage by +0.5 mV per unit
		f_cand = $signed({4'h0, freq_i}) - ACC_W'(pid_f);
		v_cand = $signed({7'h00, volt_i}) + ACC_W'(pid_v);
		// Voltage only takes over once frequency is pinned at a band edge
		at_edge = ((freq_i <= FREQ_MIN_HZ) && (pid_f > 0)) ||
			((freq_i >= FREQ_MAX_HZ) && (pid_f < 0));
		if (at_edge) begin
			freq_o = freq_i;
			volt_o = VOLT_W'(itptc_clamp(v_cand, ACC_W'(VOLT_MIN_HMV), ACC_W'(VOLT_MAX_HMV)));
		end else begin
			freq_o = FREQ_W'(itptc_clamp(f_cand, ACC_W'(FREQ_MIN_HZ), ACC_W'(FREQ_MAX_HZ)));
			volt_o = volt_i;
		end
	end
endmodule : itptc_pid
`default_nettype wire

// ---- rtl/itptc_ctrl.sv ----
/*
 * Power control sequencer for an inductive transmitter: ping with retries, then loop regulation.
 * Assumes decoded receiver packets and a sampled coil current, all synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module itptc_ctrl
	import itptc_pkg::*;
#(
	parameter int unsigned PING_WAIT_CYC = PING_WAIT_CYC_DEF,
	parameter int unsigned GAP_CYC       = GAP_CYC_DEF
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             start_i,
	input  wire logic             stop_i,
	input  wire itptc_rx_t        rx_i,
	input  wire logic [CUR_W-1:0] coil_ma_i,
	output var  itptc_cmd_t       cmd_o,
	output logic                  ping_fail_o,
	output logic                  running_o
);
	itptc_state_t      state_r, state_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic [FREQ_W-1:0] freq_r, freq_nxt;
	logic [VOLT_W-1:0] volt_r, volt_nxt;
	logic              fail_r, fail_nxt;
	itptc_cmd_t        cmd_r, cmd_nxt;
	logic [FREQ_W-1:0] pid_freq;
	logic [VOLT_W-1:0] pid_volt;
	logic              strength_pkt;
	logic              strength_ok;
	logic              ping_timeout;
	logic              retry_room;
	logic              ctrl_pkt;

	// Coil current arrives in 1 mA units, finer than the 5 mA needed
	itptc_pid u_pid (
		.coil_ma_i  (coil_ma_i),
		.ctrl_err_i (rx_i.value),
		.freq_i     (freq_r),
		.volt_i     (volt_r),
		.freq_o     (pid_freq),
		.volt_o     (pid_volt)
	);

	always_comb begin
		strength_pkt = rx_i.valid && (rx_i.kind == PKT_STRENGTH);
		strength_ok  = strength_pkt && (rx_i.value >= STRENGTH_MIN);
		ctrl_pkt     = rx_i.valid && (rx_i.kind == PKT_CTRL_ERR);
		ping_timeout = (cnt_r == CNT_W'(PING_WAIT_CYC - 1));
		retry_room   = (volt_r + VOLT_RETRY_STEP_HMV) <= VOLT_MAX_HMV;
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		freq_nxt  = freq_r;
		volt_nxt  = volt_r;
		fail_nxt  = fail_r;
		if (stop_i && (state_r != ST_IDLE)) begin
			// Host abort wins over anything the link does in the same cycle
			state_nxt = ST_IDLE;
			cnt_nxt   = '0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start_i) begin
						state_nxt = ST_PING;
						cnt_nxt   = '0;
						freq_nxt  = FREQ_PING_HZ;
						volt_nxt  = VOLT_PING_HMV;
						fail_nxt  = 1'b0;
					end
				end
				ST_PING: begin
					cnt_nxt = cnt_r + CNT_W'(1);
					if (strength_ok) begin
						state_nxt = ST_RUN;
						cnt_nxt   = '0;
					end else if (strength_pkt || ping_timeout) begin
						cnt_nxt = '0;
						if (retry_room) begin
							state_nxt = ST_GAP;
							volt_nxt  = volt_r + VOLT_RETRY_STEP_HMV;
						end else begin
							// Out of voltage headroom: give up until the next start
							state_nxt = ST_IDLE;
							fail_nxt  = 1'b1;
						end
					end
				end
				ST_GAP: begin
					cnt_nxt = cnt_r + CNT_W'(1);
					if (cnt_r == CNT_W'(GAP_CYC - 1)) begin
						state_nxt = ST_PING;
						cnt_nxt   = '0;
						freq_nxt  = FREQ_PING_HZ;
					end
				end
				ST_RUN: begin
					if (ctrl_pkt) begin
						freq_nxt = pid_freq;
						volt_nxt = pid_volt;
					end
				end
			endcase
		end
		// Hz and half-mV units give 1 Hz and 1 mV command steps, so 500 Hz steps are reachable
		cmd_nxt.power_on = (state_nxt == ST_PING) || (state_nxt == ST_RUN);
		cmd_nxt.freq_hz  = freq_nxt;
		cmd_nxt.volt_mv  = volt_nxt[VOLT_W-1:1];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
			freq_r  <= FREQ_PING_HZ;
			volt_r  <= VOLT_PING_HMV;
			fail_r  <= 1'b0;
			cmd_r   <= '{power_on: 1'b0, freq_hz: FREQ_PING_HZ, volt_mv: VOLT_PING_HMV[VOLT_W-1:1]};
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			freq_r  <= freq_nxt;
			volt_r  <= volt_nxt;
			fail_r  <= fail_nxt;
			cmd_r   <= cmd_nxt;
		end
	end

	assign cmd_o       = cmd_r;
	assign ping_fail_o = fail_r;
	assign running_o   = (state_r == ST_RUN);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_ping_start;
		(state_r == ST_IDLE) && start_i && !stop_i |=>
			cmd_o.power_on && (cmd_o.freq_hz == FREQ_PING_HZ) && (volt_r == VOLT_PING_HMV);
	endproperty
	a_ping_start: assert property (p_ping_start) else $error("first ping not 130 kHz / 8 V");

	property p_ping_freq;
		$rose(cmd_o.power_on) |-> (cmd_o.freq_hz == FREQ_PING_HZ);
	endproperty
	a_ping_freq: assert property (p_ping_freq) else $error("ping not at 130 kHz");

	property p_off_on_silence;
		(state_r == ST_PING) && ping_timeout && !rx_i.valid && !stop_i |=>
			!cmd_o.power_on [*2];
	endproperty
	a_off_on_silence: assert property (p_off_on_silence) else $error("power kept after silent ping");

	property p_retry_up;
		(state_r == ST_PING) && ping_timeout && !rx_i.valid && retry_room && !stop_i |=>
			(volt_r == $past(volt_r) + VOLT_RETRY_STEP_HMV) && (state_r == ST_GAP);
	endproperty
	a_retry_up: assert property (p_retry_up) else $error("retry voltage not stepped up");

	property p_freq_band;
		cmd_o.power_on |-> (cmd_o.freq_hz >= FREQ_MIN_HZ) && (cmd_o.freq_hz <= FREQ_MAX_HZ);
	endproperty
	a_freq_band: assert property (p_freq_band) else $error("frequency out of band");

	property p_volt_band;
		cmd_o.power_on |-> (volt_r >= VOLT_MIN_HMV) && (volt_r <= VOLT_MAX_HMV) &&
			(cmd_o.volt_mv == volt_r[VOLT_W-1:1]);
	endproperty
	a_volt_band: assert property (p_volt_band) else $error("voltage out of range");

	property p_freq_first;
		(state_r == ST_RUN) && ctrl_pkt && !stop_i &&
			(freq_r > FREQ_MIN_HZ) && (freq_r < FREQ_MAX_HZ) |=> (volt_r == $past(volt_r));
	endproperty
	a_freq_first: assert property (p_freq_first) else $error("voltage moved inside band");

	property p_freq_step;
		(state_r == ST_RUN) && ctrl_pkt && !stop_i |=>
			(int'(freq_r) - int'($past(freq_r)) <= 20000) &&
			(int'($past(freq_r)) - int'(freq_r) <= 20000);
	endproperty
	a_freq_step: assert property (p_freq_step) else $error("frequency step over limit");

	property p_volt_step;
		(state_r == ST_RUN) && ctrl_pkt && !stop_i |=>
			(int'(volt_r) - int'($past(volt_r)) <= 1500) &&
			(int'($past(volt_r)) - int'(volt_r) <= 1500);
	endproperty
	a_volt_step: assert property (p_volt_step) else $error("voltage step over limit");

	property p_run_power;
		(state_r == ST_PING) && strength_ok && !stop_i |=> running_o && cmd_o.power_on;
	endproperty
	a_run_power: assert property (p_run_power) else $error("good packet did not start transfer");

	// Last silent ping at the top voltage must end the sequence, not step past the limit
	property p_give_up;
		(state_r == ST_PING) && ping_timeout && !rx_i.valid && !retry_room && !stop_i |=>
			ping_fail_o && !cmd_o.power_on && !running_o;
	endproperty
	a_give_up: assert property (p_give_up) else $error("retries not ended at voltage limit");

	c_ping_ok:   cover property ((state_r == ST_PING) && strength_ok ##1 running_o);
	c_retry:     cover property ((state_r == ST_GAP) ##1 (state_r == ST_PING));
	c_volt_edge: cover property (running_o && ctrl_pkt ##1 (volt_r != $past(volt_r)));
	c_give_up:   cover property ($rose(ping_fail_o));
endmodule : itptc_ctrl
`default_nettype wire

// ---- bench/itptc_rx_model.sv ----
/*
 * Receiver model: answers each ping with one strength packet unless ans_i is zero, sends control errors on request.
 * Assumes the bench drives its requests just after the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module itptc_rx_model
	import itptc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       power_on_i,
	input  wire logic       clr_i,
	input  wire logic [3:0] ans_i,
	input  wire logic       err_go_i,
	input  wire logic [7:0] err_i,
	output var  itptc_rx_t  rx_o
);
	logic       pon_r;
	logic [3:0] ping_r;
	logic [2:0] dly_r;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pon_r <= 1'b0;
			ping_r <= '0;
			dly_r <= '0;
			rx_o <= '0;
		end else begin
			pon_r <= power_on_i;
			rx_o.valid <= 1'b0;
			// Idle value bits keep toggling so nothing relies on stale data
			rx_o.value <= ~rx_o.value;
			if (dly_r != 3'h0)
				dly_r <= dly_r - 3'h1;
			if (clr_i)
				ping_r <= '0;
			else if (power_on_i && !pon_r) begin
				ping_r <= ping_r + 4'h1;
				dly_r <= 3'h3;
			end
			// Answer zero before the chosen ping, stay silent when ans_i is zero
			if (dly_r == 3'h1 && ans_i != 4'h0)
				rx_o <= '{1'b1, PKT_STRENGTH, (ping_r >= ans_i) ? 8'h80 : 8'h00};
			if (err_go_i)
				rx_o <= '{1'b1, PKT_CTRL_ERR, err_i};
		end
	end
endmodule : itptc_rx_model
`default_nettype wire

// ---- bench/tb_inductive_tx_power_control.sv ----
/*
 * Self-checking bench: ping sequences with retries, random loop updates, stop.
 * Assumes shortened ping and gap counts; expectations come from integer models here.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_inductive_tx_power_control;
	import itptc_pkg::*;
	logic             clk_i, rst_n_i, start_i, stop_i, clr, err_go;
	logic [3:0]       ans;
	logic [7:0]       err_v;
	logic [CUR_W-1:0] coil_ma_i;
	itptc_rx_t        rx;
	itptc_cmd_t       cmd;
	logic             ping_fail, running;
	int               err_total, checks_done, fm, vh, n;

	itptc_ctrl #(.PING_WAIT_CYC(20), .GAP_CYC(5)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.start_i(start_i), .stop_i(stop_i), .rx_i(rx), .coil_ma_i(coil_ma_i), .cmd_o(cmd),
		.ping_fail_o(ping_fail), .running_o(running));
	itptc_rx_model rxm (.clk_i(clk_i), .rst_n_i(rst_n_i), .power_on_i(cmd.power_on),
		.clr_i(clr), .ans_i(ans), .err_go_i(err_go), .err_i(err_v), .rx_o(rx));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input int exp, input logic [31:0] got);
		checks_done++;
		if (got !== 32'(exp)) begin
			$display("unexpected %s: expected %0d seen %0d", nm, exp, got);
			err_total++;
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	task automatic wait_for(input int sel);
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk_i);
			#1;
			if ((sel == 0 && cmd.power_on === 1'b1) || (sel == 1 && cmd.power_on === 1'b0) ||
				(sel == 2 && running === 1'b1) || (sel == 3 && ping_fail === 1'b1))
				return;
		end
		$display("unexpected wait %0d: expected done seen timeout", sel);
		err_total++;
		finish_test();
	endtask : wait_for

	task automatic ping_seq(input int a);
		int vq[$];
		for (int j = 0; j < 7; j++)
			vq.push_back(8000 + 500 * j);
		@(posedge clk_i);
		ans <= a[3:0];
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		start_i <= 1'b1;
		@(posedge clk_i);
		start_i <= 1'b0;
		// Start is taken at this edge; look once the registered command has settled
		#1;
		for (int k = 1; k <= 7; k++) begin
			if (k > 1)
				wait_for(0);
			chk("ping power", 1, 32'(cmd.power_on));
			chk("ping volt", vq.pop_front(), 32'(cmd.volt_mv));
			chk("ping freq", 130000, 32'(cmd.freq_hz));
			if (k == a) begin
				wait_for(2);
				chk("running", 1, 32'(running));
				fm = 130000;
				vh = 2 * (8000 + 500 * (k - 1));
				return;
			end
			wait_for(1);
			chk("power after ping", 0, 32'(cmd.power_on));
		end
		wait_for(3);
		chk("fail power", 0, 32'(cmd.power_on));
	endtask : ping_seq

	task automatic ctrl(input logic [7:0] e, input logic [CUR_W-1:0] c);
		int p;
		@(posedge clk_i);
		err_go <= 1'b1;
		err_v <= e;
		coil_ma_i <= c;
		@(posedge clk_i);
		err_go <= 1'b0;
		@(posedge clk_i);
		#1;
		p = (int'(c) * int'(signed'(e))) >>> 7;
		if ((fm <= 110000 && p > 0) || (fm >= 180000 && p < 0)) begin
			vh += (p > 1500) ? 1500 : ((p < -1500) ? -1500 : p);
			vh = (vh < 10000) ? 10000 : ((vh > 22000) ? 22000 : vh);
		end else begin
			fm -= (p > 20000) ? 20000 : ((p < -20000) ? -20000 : p);
			fm = (fm < 110000) ? 110000 : ((fm > 180000) ? 180000 : fm);
		end
		chk("loop freq", fm, 32'(cmd.freq_hz));
		chk("loop volt", vh >>> 1, 32'(cmd.volt_mv));
	endtask : ctrl

	task automatic stop_run();
		@(posedge clk_i);
		stop_i <= 1'b1;
		@(posedge clk_i);
		stop_i <= 1'b0;
		#1;
		chk("stop power", 0, 32'(cmd.power_on));
	endtask : stop_run

	initial begin
		{rst_n_i, start_i, stop_i, clr, err_go, ans, err_v, coil_ma_i} = '0;
		err_total = 0;
		checks_done = 0;
		void'($urandom(32'h412948ea));
		@(posedge clk_i);
		#1;
		chk("reset power", 0, 32'(cmd.power_on));
		chk("reset freq", 130000, 32'(cmd.freq_hz));
		chk("reset volt", 8000, 32'(cmd.volt_mv));
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		ping_seq(1);
		// Steady sign pushes the frequency to both band edges so voltage moves too
		for (n = 0; n < 130; n++)
			ctrl((n < 40) ? 8'($urandom_range(127, 1)) :
				((n < 100) ? 8'(-$urandom_range(128, 1)) : 8'($urandom)),
				12'hc00 | 12'($urandom));
		stop_run();
		ping_seq(3);
		stop_run();
		ping_seq(0);
		chk("ping fail", 1, 32'(ping_fail));
		ping_seq(2);
		chk("fail cleared", 0, 32'(ping_fail));
		finish_test();
	end
endmodule : tb_inductive_tx_power_control
`default_nettype wire
